// file: logic/bsaf_pkg.sv
// Package for the battery condition word block: offsets, field positions, codes.
// Assumes one clock domain; shared by the design and the bench.
package bsaf_pkg;

    // Register map
    localparam logic [7:0]  BSAF_OFS_COND      = 8'h16;
    localparam logic [7:0]  BSAF_OFS_CTRL      = 8'h40;
    localparam logic [7:0]  BSAF_OFS_LEVELS    = 8'h41;
    localparam logic [7:0]  BSAF_OFS_MEAS      = 8'h42;
    localparam logic [15:0] BSAF_COND_RST      = 16'h0000;
    localparam logic [15:0] BSAF_UNMAPPED_RD   = 16'h0000;

    // Condition word bit positions
    localparam int BSAF_BIT_OVER_CHG   = 15;
    localparam int BSAF_BIT_TERM_CHG   = 14;
    localparam int BSAF_BIT_OVER_TEMP  = 12;
    localparam int BSAF_BIT_TERM_DSG   = 11;
    localparam int BSAF_BIT_CAP_ALARM  = 9;
    localparam int BSAF_BIT_TIME_ALARM = 8;
    localparam int BSAF_BIT_INIT       = 7;
    localparam int BSAF_BIT_DSG        = 6;
    localparam int BSAF_BIT_FULL       = 5;
    localparam int BSAF_BIT_EMPTY      = 4;
    localparam int BSAF_BIT_SLOPE      = 13;
    localparam int BSAF_ERR_W          = 4;

    // Control register bits
    localparam int BSAF_CTRL_LOCK      = 0;
    localparam int BSAF_CTRL_FULLCHG   = 1;

    // Thresholds
    localparam logic [7:0] BSAF_TEMP_CLR_DEGC = 8'h32;
    localparam logic [7:0] BSAF_EMPTY_CLR_PCT = 8'h14;

    typedef enum logic [3:0]
    {
        BSAF_ERR_OK       = 4'h0,
        BSAF_ERR_BUSY     = 4'h1,
        BSAF_ERR_NOTREADY = 4'h2,
        BSAF_ERR_UNSUP    = 4'h3,
        BSAF_ERR_DENIED   = 4'h4,
        BSAF_ERR_OVFL     = 4'h5,
        BSAF_ERR_BADSIZE  = 4'h6,
        BSAF_ERR_UNKNOWN  = 4'h7
    } bsaf_err_t;

endpackage

// file: logic/bsaf_status.sv
// Battery condition word: error code plus alarm and status flags.
// Assumes measurement logic supplies conditions as levels/pulses on clk_sys.
`timescale 1ns/100ps
// What this block does
// - Error code 0 when a function code was processed with no error.
// - Error code 1 when the device is busy with the function code.
// - Error code 2 when data cannot be accessed now; retry later.
// - Error code 3 for an unimplemented function code.
// - Error code 4 on writes to a read-only function code.
// - Error code 5 on data overflow or underflow.
// - Error code 6 on writes with wrong block size.
// - Error code 7 for any other detected error.
// - Next host read after an error clears the error code.
// - Over-charge alarm on temperature termination; clears on discharge or condition end.
// - Terminate-charge alarm on charge faults; clears on discharge or all faults end.
// - Slope alarm follows rate of temperature rise against programmed rate.
// - Over-temperature alarm set above limit, cleared below 50 degrees.
// - Terminate-discharge alarm follows pack voltage against final threshold.
// - Capacity alarm set below alarm level; cleared by lower level or charging.
// - Time alarm set below time setting; cleared by lower setting or valid charge.
// - Initialized set at full or empty; cleared by any reset.
// - Discharging set when not charging, cleared when charging.
// - Fully-charged set on valid termination; clears below full percentage.
// - Fully-discharged set at damage point; cleared at 20 percent charge or more.
// - Initial values come from external configuration memory.
module bsaf_status
    import bsaf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Function code completion from the host-port engine
    input  wire logic        fc_done,
    input  wire logic        fc_is_write,
    input  wire logic        fc_busy,
    input  wire logic        fc_not_ready,
    input  wire logic        fc_unsupported,
    input  wire logic        fc_read_only,
    input  wire logic        fc_overflow,
    input  wire logic        fc_bad_size,
    input  wire logic        fc_other_err,
    input  wire logic        host_read,
    // Measurement conditions
    input  wire logic        charging,
    input  wire logic        valid_charge,
    input  wire logic        charge_term,
    input  wire logic        over_current,
    input  wire logic        over_voltage,
    input  wire logic        slope_high,
    input  wire logic [7:0]  temp_degc,
    input  wire logic [15:0] pack_mv,
    input  wire logic [15:0] remaining_capacity,
    input  wire logic [15:0] full_charge_capacity,
    input  wire logic [15:0] time_to_empty,
    input  wire logic [15:0] avg_time_to_empty,
    input  wire logic [7:0]  rel_charge_pct,
    input  wire logic        reached_full,
    input  wire logic        reached_empty,
    input  wire logic        user_reset,
    input  wire logic        damage_point,
    // Configuration memory load
    input  wire logic        cfg_valid,
    input  wire logic [15:0] cfg_final_discharge_mv,
    input  wire logic [7:0]  cfg_temp_limit,
    input  wire logic [7:0]  cfg_full_pct,
    input  wire logic [15:0] cfg_cap_alarm,
    input  wire logic [15:0] cfg_time_alarm,
    input  wire logic [7:0]  cfg_lock,
    // Outputs to the gauge
    output logic      [15:0] battery_condition_word,
    output logic             charge_current_zero,
    output logic             raise_to_full,
    output logic             cfg_loaded,
    output logic             write_lock_flag
);

    // Register state
    logic [3:0]  err_r;
    logic [3:0]  err_nxt;
    logic [11:0] flags_r;
    logic [11:0] flags_nxt;
    // Settings from configuration memory and host
    logic [15:0] final_discharge_threshold_r;
    logic [15:0] final_discharge_threshold_nxt;
    logic [7:0]  temp_limit_r;
    logic [7:0]  temp_limit_nxt;
    logic [7:0]  full_pct_r;
    logic [7:0]  full_pct_nxt;
    logic [15:0] cap_alarm_r;
    logic [15:0] cap_alarm_nxt;
    logic [15:0] time_alarm_r;
    logic [15:0] time_alarm_nxt;
    logic        lock_r;
    logic        lock_nxt;
    logic        loaded_r;
    logic        loaded_nxt;
    logic        zero_r;
    logic        zero_nxt;
    logic        raise_r;
    logic        raise_nxt;
    // Read data and packed word
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [15:0] word;

    // Condition word layout; bits 3:0 of the word are the error field, the flag vector sits above
    function automatic logic [15:0] pack_word(input logic [3:0] e, input logic [11:0] f);
        pack_word = {f, e};
    endfunction

    // Bits of flags_r are word bits minus four
    function automatic int fpos(input int b);
        fpos = b - BSAF_ERR_W;
    endfunction

    // Above the programmed charge temperature limit
    function automatic logic too_hot(input logic [7:0] t, input logic [7:0] lim);
        too_hot = t > lim;
    endfunction

    // Relative charge under the full-charge percentage
    function automatic logic below_full(input logic [7:0] p, input logic [7:0] lim);
        below_full = p < lim;
    endfunction

    assign word = pack_word(err_r, flags_r);

    // Error field; a completion beats a read clear
    always_comb
    begin
        err_nxt = err_r;
        if (fc_done)
        begin
            if (fc_busy)
                err_nxt = BSAF_ERR_BUSY;
            else if (fc_not_ready)
                err_nxt = BSAF_ERR_NOTREADY;
            else if (fc_unsupported)
                err_nxt = BSAF_ERR_UNSUP;
            else if (fc_is_write && (fc_read_only || lock_r))
                err_nxt = BSAF_ERR_DENIED;
            else if (fc_overflow)
                err_nxt = BSAF_ERR_OVFL;
            else if (fc_is_write && fc_bad_size)
                err_nxt = BSAF_ERR_BADSIZE;
            else if (fc_other_err || (!fc_is_write && fc_bad_size))
                err_nxt = BSAF_ERR_UNKNOWN;
            else
                err_nxt = BSAF_ERR_OK;
        end
        // A host read, or a register read of the condition word, clears a stored error
        else if (host_read || (reg_rd && reg_addr == BSAF_OFS_COND))
            err_nxt = BSAF_ERR_OK;
    end

    // Alarm and status flags
    always_comb
    begin
        flags_nxt = flags_r;
        raise_nxt = 1'b0;
        // Over-charge alarm
        if (!charging)
            flags_nxt[fpos(BSAF_BIT_OVER_CHG)] = 1'b0;
        else if (charge_term && (slope_high || too_hot(temp_degc, temp_limit_r)))
            flags_nxt[fpos(BSAF_BIT_OVER_CHG)] = 1'b1;
        else if (!slope_high && !too_hot(temp_degc, temp_limit_r))
            flags_nxt[fpos(BSAF_BIT_OVER_CHG)] = 1'b0;

        // Terminate-charge alarm
        if (!charging)
            flags_nxt[fpos(BSAF_BIT_TERM_CHG)] = 1'b0;
        else
            flags_nxt[fpos(BSAF_BIT_TERM_CHG)] = over_current || over_voltage || slope_high
                                                  || too_hot(temp_degc, temp_limit_r);

        // Temperature slope alarm
        flags_nxt[fpos(BSAF_BIT_SLOPE)] = slope_high;

        // Over-temperature alarm, held down to the clear level
        if (too_hot(temp_degc, temp_limit_r))
            flags_nxt[fpos(BSAF_BIT_OVER_TEMP)] = 1'b1;
        else if (temp_degc < BSAF_TEMP_CLR_DEGC)
            flags_nxt[fpos(BSAF_BIT_OVER_TEMP)] = 1'b0;

        // Terminate-discharge alarm
        flags_nxt[fpos(BSAF_BIT_TERM_DSG)] = pack_mv <= final_discharge_threshold_r;

        // Remaining-capacity alarm
        if (remaining_capacity < cap_alarm_r)
            flags_nxt[fpos(BSAF_BIT_CAP_ALARM)] = 1'b1;
        else if (charging || cap_alarm_r < remaining_capacity)
            flags_nxt[fpos(BSAF_BIT_CAP_ALARM)] = 1'b0;

        // Remaining-time alarm
        if (valid_charge || time_alarm_r < avg_time_to_empty)
            flags_nxt[fpos(BSAF_BIT_TIME_ALARM)] = 1'b0;
        else if (time_to_empty < time_alarm_r)
            flags_nxt[fpos(BSAF_BIT_TIME_ALARM)] = 1'b1;

        // Initialized; a full or empty event wins over a user reset
        if (reached_full || reached_empty)
            flags_nxt[fpos(BSAF_BIT_INIT)] = 1'b1;
        else if (user_reset)
            flags_nxt[fpos(BSAF_BIT_INIT)] = 1'b0;

        // Discharging
        flags_nxt[fpos(BSAF_BIT_DSG)] = !charging;

        // Fully charged; asks the gauge to raise remaining capacity
        if (charge_term)
        begin
            flags_nxt[fpos(BSAF_BIT_FULL)] = 1'b1;
            raise_nxt = below_full(rel_charge_pct, full_pct_r);
        end
        else if (below_full(rel_charge_pct, full_pct_r))
            flags_nxt[fpos(BSAF_BIT_FULL)] = 1'b0;

        // Fully discharged
        if (damage_point)
            flags_nxt[fpos(BSAF_BIT_EMPTY)] = 1'b1;
        else if (rel_charge_pct >= BSAF_EMPTY_CLR_PCT)
            flags_nxt[fpos(BSAF_BIT_EMPTY)] = 1'b0;

        // No flags are reported before the configuration load
        if (!loaded_r)
        begin
            flags_nxt = '0;
            raise_nxt = 1'b0;
        end
        // Current request follows the alarm as registered
        zero_nxt = flags_nxt[fpos(BSAF_BIT_TERM_CHG)];
    end

    // Configuration and host-writable settings
    always_comb
    begin
        final_discharge_threshold_nxt = final_discharge_threshold_r;
        temp_limit_nxt = temp_limit_r;
        full_pct_nxt   = full_pct_r;
        cap_alarm_nxt  = cap_alarm_r;
        time_alarm_nxt = time_alarm_r;
        lock_nxt       = lock_r;
        loaded_nxt     = loaded_r;
        // A configuration load beats a host write
        if (cfg_valid)
        begin
            final_discharge_threshold_nxt = cfg_final_discharge_mv;
            temp_limit_nxt = cfg_temp_limit;
            full_pct_nxt   = cfg_full_pct;
            cap_alarm_nxt  = cfg_cap_alarm;
            time_alarm_nxt = cfg_time_alarm;
            lock_nxt       = cfg_lock[BSAF_CTRL_LOCK];
            loaded_nxt     = 1'b1;
        end
        else if (reg_wr && !lock_r)
        begin
            case (reg_addr)
                BSAF_OFS_CTRL:   lock_nxt = reg_wdata[BSAF_CTRL_LOCK];
                BSAF_OFS_LEVELS: cap_alarm_nxt = reg_wdata;
                BSAF_OFS_MEAS:   time_alarm_nxt = reg_wdata;
                default:         lock_nxt = lock_r;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_comb
    begin
        case (reg_addr)
            BSAF_OFS_COND:   rdata_nxt = word;
            BSAF_OFS_CTRL:   rdata_nxt = {14'h0000, loaded_r, lock_r};
            BSAF_OFS_LEVELS: rdata_nxt = cap_alarm_r;
            BSAF_OFS_MEAS:   rdata_nxt = time_alarm_r;
            default:         rdata_nxt = BSAF_UNMAPPED_RD;
        endcase
        if (!reg_rd)
            rdata_nxt = 16'h0000;
    end

    // Error field register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            err_r <= BSAF_ERR_OK;
        end
        else
        begin
            err_r <= err_nxt;
        end
    end

    // Flag registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            flags_r <= 12'h000;
            zero_r  <= 1'b0;
            raise_r <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            zero_r  <= zero_nxt;
            raise_r <= raise_nxt;
        end
    end

    // Setting registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            final_discharge_threshold_r <= 16'h0000;
            temp_limit_r <= 8'hFF;
            full_pct_r   <= 8'h00;
            cap_alarm_r  <= 16'h0000;
            time_alarm_r <= 16'h0000;
            lock_r       <= 1'b0;
            loaded_r     <= 1'b0;
        end
        else
        begin
            final_discharge_threshold_r <= final_discharge_threshold_nxt;
            temp_limit_r <= temp_limit_nxt;
            full_pct_r   <= full_pct_nxt;
            cap_alarm_r  <= cap_alarm_nxt;
            time_alarm_r <= time_alarm_nxt;
            lock_r       <= lock_nxt;
            loaded_r     <= loaded_nxt;
        end
    end

    // Read data register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rdata_r <= 16'h0000;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // Packed word, updated together with its fields
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            battery_condition_word <= BSAF_COND_RST;
        end
        else
        begin
            battery_condition_word <= pack_word(err_nxt, flags_nxt);
        end
    end

    // Outputs straight from registers
    assign reg_rdata           = rdata_r;
    assign charge_current_zero = zero_r;
    assign raise_to_full       = raise_r;
    assign cfg_loaded          = loaded_r;
    assign write_lock_flag     = lock_r;

endmodule

// file: test/bsaf_props.sv
// Concurrent checks on the condition word block, seen from its ports.
// Assumes one clock clk_sys and synchronous reset srst; bound below.
`timescale 1ns/100ps
module bsaf_props
    import bsaf_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        srst,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Host side events
    input wire logic        fc_done,
    input wire logic        fc_busy,
    input wire logic        host_read,
    // Measurements
    input wire logic        charging,
    input wire logic [7:0]  temp_degc,
    input wire logic [15:0] pack_mv,
    input wire logic [15:0] cfg_final_discharge_mv,
    // Outputs
    input wire logic [15:0] battery_condition_word,
    input wire logic        charge_current_zero,
    input wire logic        cfg_loaded
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_busy_done;
        fc_done && fc_busy;
    endsequence
    sequence s_host_clear;
        (host_read || (reg_rd && reg_addr == BSAF_OFS_COND)) && !fc_done;
    endsequence
    a_err_busy: assert property (s_busy_done |=> battery_condition_word[3:0] == 4'h1)
        else $error("busy code not reported");
    a_read_clears: assert property (s_host_clear |=> battery_condition_word[3:0] == 4'h0)
        else $error("read did not clear the error code");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_rdata_word: assert property (reg_rd && reg_addr == BSAF_OFS_COND |=> reg_rdata == $past(battery_condition_word))
        else $error("read data differs from the condition word");
    a_dsg_set: assert property (cfg_loaded && !charging |=> battery_condition_word[BSAF_BIT_DSG])
        else $error("discharging flag not set");
    a_dsg_clear: assert property (charging |=> !battery_condition_word[BSAF_BIT_DSG])
        else $error("discharging flag set while charging");
    a_temp_clear: assert property (temp_degc < BSAF_TEMP_CLR_DEGC |=> !battery_condition_word[BSAF_BIT_OVER_TEMP])
        else $error("over temperature flag held below clear level");
    a_tdsg_set: assert property (cfg_loaded && pack_mv < cfg_final_discharge_mv |=> battery_condition_word[11])
        else $error("terminate discharge flag not set");
    a_tdsg_clear: assert property (pack_mv > cfg_final_discharge_mv |=> !battery_condition_word[11])
        else $error("terminate discharge flag held above threshold");
    a_czero_follow: assert property (charge_current_zero == battery_condition_word[BSAF_BIT_TERM_CHG])
        else $error("charge current zero differs from terminate charge flag");
    a_bit_unused: assert property (battery_condition_word[10] == 1'b0)
        else $error("unused word bit set");
endmodule
bind bsaf_status bsaf_props bsaf_props_inst (.clk_sys, .srst, .reg_addr, .reg_rd, .reg_rdata, .fc_done, .fc_busy,
    .host_read, .charging, .temp_degc, .pack_mv, .cfg_final_discharge_mv, .battery_condition_word,
    .charge_current_zero, .cfg_loaded);

// file: test/bsaf_host_model.sv
// Host model: function code completions and serial reads of the block.
// Assumes one clock clk_sys; its tasks are called by the bench.
`timescale 1ns/100ps
module bsaf_host_model
(
    // Clock
    input  wire logic       clk_sys,
    // Completion to the block
    output logic            fc_done,
    output logic            fc_is_write,
    output logic      [6:0] fc_err,
    output logic            host_read
);
    initial
    begin
        fc_done = 1'b0;
        fc_is_write = 1'b0;
        fc_err = 7'h00;
        host_read = 1'b0;
    end
    // Qualifiers mean nothing outside fc_done, so they show junk there
    task automatic send(input logic wr, input logic [6:0] err);
        @(posedge clk_sys);
        fc_is_write <= wr;
        fc_err <= err;
        fc_done <= 1'b1;
        @(posedge clk_sys);
        fc_done <= 1'b0;
        fc_is_write <= ~wr;
        fc_err <= ~err;
        #1;
    endtask
    task automatic rd_word();
        @(posedge clk_sys);
        host_read <= 1'b1;
        @(posedge clk_sys);
        host_read <= 1'b0;
        #1;
    endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the condition word block.
// Assumes the host model drives completions; one clock, sync reset.
`timescale 1ns/100ps
module tb_top;
    import bsaf_pkg::*;
    logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cfg_valid = 1'b0, charging = 1'b0;
    logic valid_charge = 1'b0, charge_term = 1'b0, over_current = 1'b0, over_voltage = 1'b0, slope_high = 1'b0;
    logic reached_full = 1'b0, reached_empty = 1'b0, user_reset = 1'b0, damage_point = 1'b0;
    logic [7:0] reg_addr = 8'h00, temp_degc = 8'h19, rel_charge_pct = 8'h13, cfg_temp_limit = 8'h3C;
    logic [7:0] cfg_full_pct = 8'h5A, cfg_lock = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, pack_mv = 16'h2EE0, remaining_capacity = 16'h03E8;
    logic [15:0] full_charge_capacity = 16'h0708, time_to_empty = 16'h00FF, avg_time_to_empty = 16'h00FF;
    logic [15:0] cfg_final_discharge_mv = 16'h2328, cfg_cap_alarm = 16'h00B4, cfg_time_alarm = 16'h000A;
    logic [15:0] reg_rdata, cw, d;
    logic [6:0] fc_err;
    logic fc_done, fc_is_write, host_read, charge_current_zero, cfg_loaded, write_lock_flag, raise_to_full;
    int bad_count = 0, compares = 0;
    bsaf_host_model bsaf_host_model_inst (.clk_sys, .fc_done, .fc_is_write, .fc_err, .host_read);
    bsaf_status bsaf_status_inst (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .fc_done, .fc_is_write, .fc_busy(fc_err[0]), .fc_not_ready(fc_err[1]), .fc_unsupported(fc_err[2]),
        .fc_read_only(fc_err[3]), .fc_overflow(fc_err[4]), .fc_bad_size(fc_err[5]), .fc_other_err(fc_err[6]),
        .host_read, .charging, .valid_charge, .charge_term, .over_current, .over_voltage, .slope_high,
        .temp_degc, .pack_mv, .remaining_capacity, .full_charge_capacity, .time_to_empty, .avg_time_to_empty,
        .rel_charge_pct, .reached_full, .reached_empty, .user_reset, .damage_point, .cfg_valid,
        .cfg_final_discharge_mv, .cfg_temp_limit, .cfg_full_pct, .cfg_cap_alarm, .cfg_time_alarm, .cfg_lock,
        .battery_condition_word(cw), .charge_current_zero, .raise_to_full, .cfg_loaded, .write_lock_flag);
    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input int b, input logic e);
        chk(n, {15'h0000, e}, {15'h0000, cw[b]});
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic t_reset();
        chk("word_reset", BSAF_COND_RST, cw);
        rd_reg(BSAF_OFS_COND);
        chk("word_before_cfg", 16'h0000, d);
        @(posedge clk_sys);
        cfg_valid <= 1'b1;
        @(posedge clk_sys);
        cfg_valid <= 1'b0;
        tick();
        chk("cfg_loaded", 16'h0001, {15'h0000, cfg_loaded});
        chk_bit("discharging", BSAF_BIT_DSG, 1'b1);
    endtask
    task automatic t_errors();
        for (int i = 0; i < 7; i++)
        begin
            bsaf_host_model_inst.send(1'b1, 7'(7'h01 << i));
            chk("err_code", 16'(i + 1), {12'h000, cw[3:0]});
            rd_reg(BSAF_OFS_COND);
            chk("err_read", 16'(i + 1), {12'h000, d[3:0]});
            chk("err_cleared", 16'h0000, {12'h000, cw[3:0]});
        end
        bsaf_host_model_inst.send(1'b1, 7'h34);
        chk("err_priority", 16'h0003, {12'h000, cw[3:0]});
        bsaf_host_model_inst.send(1'b1, 7'h00);
        chk("err_ok_write", 16'h0000, {12'h000, cw[3:0]});
        bsaf_host_model_inst.send(1'b0, 7'h40);
        chk("err_unknown_read", 16'h0007, {12'h000, cw[3:0]});
        bsaf_host_model_inst.send(1'b0, 7'h00);
        chk("err_ok", 16'h0000, {12'h000, cw[3:0]});
        bsaf_host_model_inst.send(1'b0, 7'h40);
        bsaf_host_model_inst.rd_word();
        chk("err_host_clear", 16'h0000, {12'h000, cw[3:0]});
    endtask
    task automatic t_levels();
        @(posedge clk_sys);
        temp_degc <= 8'h3D;
        pack_mv <= 16'h2327;
        remaining_capacity <= 16'h0064;
        time_to_empty <= 16'h0005;
        avg_time_to_empty <= 16'h0005;
        tick();
        chk_bit("over_temp", BSAF_BIT_OVER_TEMP, 1'b1);
        chk_bit("term_dsg", BSAF_BIT_TERM_DSG, 1'b1);
        chk_bit("cap_alarm", BSAF_BIT_CAP_ALARM, 1'b1);
        chk_bit("time_alarm", BSAF_BIT_TIME_ALARM, 1'b1);
        @(posedge clk_sys);
        temp_degc <= BSAF_TEMP_CLR_DEGC;
        pack_mv <= 16'h2329;
        tick();
        chk_bit("over_temp_hold", BSAF_BIT_OVER_TEMP, 1'b1);
        chk_bit("term_dsg_clear", BSAF_BIT_TERM_DSG, 1'b0);
        @(posedge clk_sys);
        temp_degc <= 8'h31;
        tick();
        chk_bit("over_temp_clear", BSAF_BIT_OVER_TEMP, 1'b0);
        wr_reg(BSAF_OFS_LEVELS, 16'h0032);
        tick();
        chk_bit("cap_alarm_clear", BSAF_BIT_CAP_ALARM, 1'b0);
        wr_reg(BSAF_OFS_CTRL, 16'h0001);
        tick();
        chk("lock_flag", 16'h0001, {15'h0000, write_lock_flag});
        wr_reg(BSAF_OFS_LEVELS, 16'hFFFF);
        tick();
        chk_bit("locked_write_ignored", BSAF_BIT_CAP_ALARM, 1'b0);
        rd_reg(8'h77);
        chk("unmapped_read", BSAF_UNMAPPED_RD, d);
    endtask
    task automatic t_charge();
        @(posedge clk_sys);
        charging <= 1'b1;
        over_voltage <= 1'b1;
        slope_high <= 1'b1;
        damage_point <= 1'b1;
        reached_full <= 1'b1;
        tick();
        chk_bit("dsg_clear", BSAF_BIT_DSG, 1'b0);
        chk_bit("term_chg", BSAF_BIT_TERM_CHG, 1'b1);
        chk_bit("slope", BSAF_BIT_SLOPE, 1'b1);
        chk_bit("empty", BSAF_BIT_EMPTY, 1'b1);
        chk_bit("init_full", BSAF_BIT_INIT, 1'b1);
        @(posedge clk_sys);
        over_voltage <= 1'b0;
        slope_high <= 1'b0;
        valid_charge <= 1'b1;
        damage_point <= 1'b0;
        reached_full <= 1'b0;
        rel_charge_pct <= BSAF_EMPTY_CLR_PCT;
        user_reset <= 1'b1;
        tick();
        chk_bit("term_chg_clear", BSAF_BIT_TERM_CHG, 1'b0);
        chk_bit("slope_clear", BSAF_BIT_SLOPE, 1'b0);
        chk_bit("time_alarm_clear", BSAF_BIT_TIME_ALARM, 1'b0);
        chk_bit("empty_clear", BSAF_BIT_EMPTY, 1'b0);
        chk_bit("init_clear", BSAF_BIT_INIT, 1'b0);
        @(posedge clk_sys);
        user_reset <= 1'b0;
        reached_empty <= 1'b1;
        charge_term <= 1'b1;
        @(posedge clk_sys);
        reached_empty <= 1'b0;
        charge_term <= 1'b0;
        #1;
        chk_bit("init_empty", BSAF_BIT_INIT, 1'b1);
        chk_bit("full", BSAF_BIT_FULL, 1'b1);
        chk("raise_full", 16'h0001, {15'h0000, raise_to_full});
        @(posedge clk_sys);
        charge_term <= 1'b1;
        slope_high <= 1'b1;
        @(posedge clk_sys);
        charge_term <= 1'b0;
        slope_high <= 1'b0;
        #1;
        chk_bit("over_chg", BSAF_BIT_OVER_CHG, 1'b1);
        tick();
        chk_bit("over_chg_clear", BSAF_BIT_OVER_CHG, 1'b0);
        chk("raise_pulse", 16'h0000, {15'h0000, raise_to_full});
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        tick();
        t_reset();
        t_errors();
        t_levels();
        t_charge();
        print_verdict();
    end
    initial
    begin
        #100000;
        bad_count++;
        print_verdict();
    end
endmodule
